// ==== logic/cep_pkg.sv ====
package cep_pkg;

   // vector addresses of the exception table
   localparam logic [31:0] CEP_VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] CEP_VEC_UNDEF = 32'h0000_0004;
   localparam logic [31:0] CEP_VEC_TRAP  = 32'h0000_0008;
   localparam logic [31:0] CEP_VEC_PABT  = 32'h0000_000c;
   localparam logic [31:0] CEP_VEC_DABT  = 32'h0000_0010;
   localparam logic [31:0] CEP_VEC_RSVD  = 32'h0000_0014;
   localparam logic [31:0] CEP_VEC_IRQ   = 32'h0000_0018;
   localparam logic [31:0] CEP_VEC_FAST  = 32'h0000_001c;

   // register file layout
   localparam int CEP_NUM_REGS  = 16;
   localparam int CEP_SP_IDX    = 13;
   localparam int CEP_LR_IDX    = 14;
   localparam int CEP_PC_IDX    = 15;
   localparam int CEP_FAST_LO   = 8;
   localparam int CEP_FAST_HI   = 12;
   localparam int CEP_NUM_LVLS  = 8;
   localparam int CEP_LVL_W     = 3;

   // minimum interrupt entry: two sync stages plus three entry cycles
   localparam int CEP_MIN_LATENCY = 5;
   localparam int CEP_SYNC_STAGES = 2;
   localparam int CEP_ENTRY_CYC   = CEP_MIN_LATENCY - CEP_SYNC_STAGES;

   // transfer widths on the shared bus
   localparam logic [1:0] CEP_SIZE_BYTE = 2'h0;
   localparam logic [1:0] CEP_SIZE_HALF = 2'h1;
   localparam logic [1:0] CEP_SIZE_WORD = 2'h2;

   typedef enum logic [2:0] {
      CEP_MODE_USER,
      CEP_MODE_FAST,
      CEP_MODE_IRQ,
      CEP_MODE_SVC,
      CEP_MODE_ABT,
      CEP_MODE_UND
   } cep_mode_t;

   // exception requests from the rest of the core
   typedef struct packed {
      logic data_abort;
      logic prefetch_abort;
      logic software_trap_instruction;
      logic undefined_instr;
   } cep_exc_req_t;

   // shared bus request
   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cep_bus_req_t;

   // debug access from the jtag side
   typedef struct packed {
      logic        bkpt_wr;
      logic [31:0] bkpt_val;
      logic        wpt_wr;
      logic [31:0] wpt_val;
      logic        reg_rd;
      logic [3:0]  reg_idx;
      logic        mem_rd;
      logic [31:0] mem_addr;
      logic        resume;
   } cep_dbg_req_t;

endpackage

// ==== logic/cep_mac.sv ====
`timescale 1ns/1ns
module cep_mac
   import cep_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic             clk_sys_i, // core clock
   input  wire logic             rst_n_i,   // sync reset
   input  wire logic             start_i,   // launch operation
   input  wire logic             acc_i,     // accumulate into result
   input  wire logic [W-1:0]     a_i,       // operand a
   input  wire logic [W-1:0]     b_i,       // operand b
   output logic      [2*W-1:0]   result_o   // double-width result
);

   // multiply or multiply-accumulate, one result per start
   // RL16: double-width product
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         result_o <= '0;
      end else if (start_i) begin
         result_o <= (acc_i ? result_o : '0) + (2*W)'(a_i) * (2*W)'(b_i);
      end
   end

   // RL16: product width check
   prod_width_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL16
      start_i && !acc_i |=> result_o == (2*W)'($past(a_i)) * (2*W)'($past(b_i)))
      else $error("multiply result wrong");

endmodule

// ==== logic/cep_core.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// RL1: exception entry fetches from its fixed vector address.
// RL2: priority is reset, data abort, fast, normal, prefetch, then trap/undefined.
// RL3: trap and undefined share lowest priority and never come together.
// RL4: slot 0x14 is never used; table spans 0x00 to 0x1c.
// RL5: fast interrupt wins over normal interrupt when both pending.
// RL6: each interrupt type ranks its sources over eight levels.
// RL7: first instruction at any vector runs in the 32-bit state.
// RL8: breakpoint or watchpoint match halts the core into debug state.
// RL9: breakpoint and watchpoint values are written only via the debug port.
// RL10: halted debugger may read core registers and memory.
// RL11: sixteen general registers; 13 stack, 14 link, 15 program counter.
// RL12: link captures return address on branch-link or exception.
// RL13: every exception mode has its own stack pointer.
// RL14: one shared 32-bit bus, transfers of 8, 16 or 32 bits; the core issues only 32-bit word transfers.
// RL15: instructions are 16 bits compressed, 32 bits normal.
// RL16: multiplier gives 64-bit results for multiply and accumulate.
// RL17: fast mode banks its own registers 8 to 12.
// RL18: fastest interrupt to entry takes five core cycles.
// RL19: interrupt requests are synchronised before prioritisation.
// RL20: reset overrides everything and returns to 32-bit state at zero.
module cep_core
   import cep_pkg::*;
#(
   parameter int NSRC = 8
) (
   input  wire logic              clk_sys_i,     // core clock, 250 MHz
   input  wire logic              rst_n_i,       // sync reset, active low
   input  wire logic [NSRC-1:0]   irq_src_i,     // normal interrupt sources, async
   input  wire logic [NSRC-1:0]   fast_src_i,    // fast interrupt sources, async
   input  wire logic [NSRC*3-1:0] src_lvl_i,     // per-source level, 0 highest
   input  wire cep_exc_req_t      exc_req_i,     // synchronous exception requests
   input  wire logic              branch_link_i, // branch-with-link executes
   input  wire logic [31:0]       ret_addr_i,    // return address for branch-link
   input  wire logic [31:0]       cur_pc_i,      // address of current instruction
   input  wire logic [31:0]       bus_addr_i,    // data address for watchpoint
   input  wire logic              compressed_i,  // core in 16-bit state
   input  wire logic [3:0]        wr_idx_i,      // register write index
   input  wire logic              wr_en_i,       // register write enable
   input  wire logic [31:0]       wr_data_i,     // register write data
   input  wire logic              mac_start_i,   // start multiply
   input  wire logic              mac_acc_i,     // accumulate
   input  wire logic [31:0]       mac_a_i,       // multiplier operand a
   input  wire logic [31:0]       mac_b_i,       // multiplier operand b
   input  wire cep_dbg_req_t      dbg_i,         // debug port requests
   input  wire logic [31:0]       bus_rdata_i,   // shared bus read data
   output cep_bus_req_t           bus_o,         // shared bus request
   output logic [31:0]            vec_addr_o,    // vector being entered
   output logic                   exc_enter_o,   // one-cycle entry pulse
   output cep_mode_t              mode_o,        // current processor mode
   output logic                   wide_state_o,  // 1 = 32-bit instruction state
   output logic [5:0]             fetch_bits_o,  // instruction width (16 or 32)
   output logic                   halted_o,      // debug state
   output logic [31:0]            dbg_rdata_o,   // debug read data
   output logic                   dbg_rvalid_o,  // debug read data valid
   output logic [63:0]            mac_result_o   // multiplier result
);

   // two-stage synchronisers; stage one is read only by stage two
   logic [NSRC-1:0] irq_s1, irq_s2, fast_s1, fast_s2;
   // RL19: synchronise requests
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_s1  <= '0;
         irq_s2  <= '0;
         fast_s1 <= '0;
         fast_s2 <= '0;
      end else begin
         irq_s1  <= irq_src_i;
         irq_s2  <= irq_s1;
         fast_s1 <= fast_src_i;
         fast_s2 <= fast_s1;
      end
   end

   // RL6: per-source level mask, one bit per level per type
   logic [CEP_NUM_LVLS-1:0] irq_lvl_hit, fast_lvl_hit;
   logic [CEP_LVL_W-1:0]    irq_best, fast_best;
   genvar g;
   generate
      for (g = 0; g < CEP_NUM_LVLS; g++) begin : g_lvl
         always_comb begin
            irq_lvl_hit[g]  = 1'b0;
            fast_lvl_hit[g] = 1'b0;
            for (int s = 0; s < NSRC; s++) begin
               if (src_lvl_i[s*3 +: 3] == CEP_LVL_W'(g)) begin
                  irq_lvl_hit[g]  = irq_lvl_hit[g] | irq_s2[s];
                  fast_lvl_hit[g] = fast_lvl_hit[g] | fast_s2[s];
               end
            end
         end
      end
   endgenerate

   // best pending level, lowest number wins
   always_comb begin
      irq_best  = '1;
      fast_best = '1;
      for (int l = CEP_NUM_LVLS-1; l >= 0; l--) begin
         if (irq_lvl_hit[l]) irq_best = CEP_LVL_W'(l);
         if (fast_lvl_hit[l]) fast_best = CEP_LVL_W'(l);
      end
   end

   // entry pipe advances only while the request stands, so nothing stale fires later
   logic [CEP_ENTRY_CYC-1:0] fast_pipe, irq_pipe;
   logic                     in_svc, take;
   logic [31:0]              next_vec;
   cep_mode_t                next_mode;
   wire fast_clr = !(|fast_lvl_hit) || in_svc || halted_o || (take && next_mode == CEP_MODE_FAST);
   wire irq_clr  = !(|irq_lvl_hit) || in_svc || halted_o || (take && next_mode == CEP_MODE_IRQ);
   // RL18: entry latency pipe
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         fast_pipe <= '0;
         irq_pipe  <= '0;
      end else begin
         fast_pipe <= fast_clr ? '0 : {fast_pipe[CEP_ENTRY_CYC-2:0], 1'b1};
         irq_pipe  <= irq_clr ? '0 : {irq_pipe[CEP_ENTRY_CYC-2:0], 1'b1};
      end
   end
   wire fast_rdy = fast_pipe[CEP_ENTRY_CYC-2] & |fast_lvl_hit & !in_svc;
   wire irq_rdy  = irq_pipe[CEP_ENTRY_CYC-2] & |irq_lvl_hit & !in_svc;

   // priority select; the reserved slot 0x14 is never produced
   // RL2: fixed ranking
   // RL5: fast before normal
   // RL3: trap then undefined at lowest priority
   always_comb begin
      take      = 1'b1;
      next_vec  = CEP_VEC_RESET;
      next_mode = CEP_MODE_SVC;
      if (exc_req_i.data_abort) begin
         next_vec  = CEP_VEC_DABT;
         next_mode = CEP_MODE_ABT;
      end else if (fast_rdy) begin
         next_vec  = CEP_VEC_FAST;
         next_mode = CEP_MODE_FAST;
      end else if (irq_rdy) begin
         next_vec  = CEP_VEC_IRQ;
         next_mode = CEP_MODE_IRQ;
      end else if (exc_req_i.prefetch_abort) begin
         next_vec  = CEP_VEC_PABT;
         next_mode = CEP_MODE_ABT;
      end else if (exc_req_i.software_trap_instruction) begin
         next_vec  = CEP_VEC_TRAP;
         next_mode = CEP_MODE_SVC;
      end else if (exc_req_i.undefined_instr) begin
         next_vec  = CEP_VEC_UNDEF;
         next_mode = CEP_MODE_UND;
      end else begin
         take = 1'b0;
      end
      if (halted_o) take = 1'b0;
   end
   assign in_svc = exc_enter_o;

   // breakpoint / watchpoint values, written only from the debug port
   logic [31:0] bkpt_val, wpt_val;
   logic        bkpt_on, wpt_on;
   // RL9: debug port writes only
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         bkpt_val <= '0;
         wpt_val  <= '0;
         bkpt_on  <= 1'b0;
         wpt_on   <= 1'b0;
      end else begin
         if (dbg_i.bkpt_wr) begin
            bkpt_val <= dbg_i.bkpt_val;
            bkpt_on  <= 1'b1;
         end
         if (dbg_i.wpt_wr) begin
            wpt_val <= dbg_i.wpt_val;
            wpt_on  <= 1'b1;
         end
      end
   end
   wire dbg_match = (bkpt_on && cur_pc_i == bkpt_val) || (wpt_on && bus_addr_i == wpt_val);

   // halt on match; leaves only on a resume from the debugger
   // RL8: halt into debug state
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) halted_o <= 1'b0;
      else if (dbg_match) halted_o <= 1'b1;
      else if (dbg_i.resume) halted_o <= 1'b0;
   end

   // entry, vector, mode and instruction state
   // RL1: vector fetch on entry
   // RL7: vectors run in 32-bit state
   // RL20: reset returns to vector zero
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         exc_enter_o  <= 1'b1;
         vec_addr_o   <= CEP_VEC_RESET;
         mode_o       <= CEP_MODE_SVC;
         wide_state_o <= 1'b1;
      end else if (take) begin
         exc_enter_o  <= 1'b1;
         vec_addr_o   <= next_vec;
         mode_o       <= next_mode;
         wide_state_o <= 1'b1;
      end else begin
         exc_enter_o  <= 1'b0;
         wide_state_o <= !compressed_i;
      end
   end

   // RL15: instruction width follows state
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) fetch_bits_o <= 6'h20;
      else fetch_bits_o <= (take || !compressed_i) ? 6'h20 : 6'h10;
   end

   // general registers plus banks; r8-r12 banked for fast mode, sp/lr per mode
   // RL11: sixteen general registers
   logic [31:0] gpr [CEP_NUM_REGS];
   logic [31:0] fast_bank [CEP_FAST_LO:CEP_FAST_HI];
   logic [31:0] sp_bank [6];
   logic [31:0] lr_bank [6];
   wire  is_fast = (mode_o == CEP_MODE_FAST);
   // RL17: fast mode bank
   // RL13: stack per mode
   // RL12: link capture
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < CEP_NUM_REGS; i++) gpr[i] <= '0;
         for (int i = CEP_FAST_LO; i <= CEP_FAST_HI; i++) fast_bank[i] <= '0;
         for (int i = 0; i < 6; i++) begin
            sp_bank[i] <= '0;
            lr_bank[i] <= '0;
         end
      end else if (take) begin
         lr_bank[next_mode] <= cur_pc_i;
         gpr[CEP_PC_IDX]    <= next_vec;
      end else begin
         if (branch_link_i) lr_bank[mode_o] <= ret_addr_i;
         if (wr_en_i) begin
            if (wr_idx_i == 4'(CEP_SP_IDX)) sp_bank[mode_o] <= wr_data_i;
            else if (wr_idx_i == 4'(CEP_LR_IDX)) lr_bank[mode_o] <= wr_data_i;
            else if (is_fast && wr_idx_i >= 4'(CEP_FAST_LO) && wr_idx_i <= 4'(CEP_FAST_HI))
               fast_bank[wr_idx_i] <= wr_data_i;
            else gpr[wr_idx_i] <= wr_data_i;
         end
      end
   end

   // debug reads while halted: registers or memory over the bus
   logic [31:0] reg_view;
   always_comb begin
      if (dbg_i.reg_idx == 4'(CEP_SP_IDX)) reg_view = sp_bank[mode_o];
      else if (dbg_i.reg_idx == 4'(CEP_LR_IDX)) reg_view = lr_bank[mode_o];
      else if (is_fast && dbg_i.reg_idx >= 4'(CEP_FAST_LO) && dbg_i.reg_idx <= 4'(CEP_FAST_HI))
         reg_view = fast_bank[dbg_i.reg_idx];
      else reg_view = gpr[dbg_i.reg_idx];
   end
   logic mem_pend;
   // RL10: debugger reads when halted
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dbg_rdata_o  <= '0;
         dbg_rvalid_o <= 1'b0;
         mem_pend     <= 1'b0;
      end else begin
         dbg_rvalid_o <= 1'b0;
         mem_pend     <= halted_o && dbg_i.mem_rd;
         if (halted_o && dbg_i.reg_rd) begin
            dbg_rdata_o  <= reg_view;
            dbg_rvalid_o <= 1'b1;
         end else if (mem_pend) begin
            dbg_rdata_o  <= bus_rdata_i;
            dbg_rvalid_o <= 1'b1;
         end
      end
   end

   // shared bus: vector fetch or debug memory read, one word each
   // RL14: single shared bus
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         bus_o <= '0;
      end else begin
         bus_o.valid <= take || (halted_o && dbg_i.mem_rd);
         bus_o.fetch <= take;
         bus_o.write <= 1'b0;
         bus_o.size  <= CEP_SIZE_WORD;
         bus_o.addr  <= take ? next_vec : dbg_i.mem_addr;
         bus_o.wdata <= '0;
      end
   end

   cep_mac u_mac (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (mac_start_i),
      .acc_i     (mac_acc_i),
      .a_i       (mac_a_i),
      .b_i       (mac_b_i),
      .result_o  (mac_result_o)
   );

   // RL4: reserved slot unused
   vec_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL4
      exc_enter_o |-> vec_addr_o != CEP_VEC_RSVD && vec_addr_o <= CEP_VEC_FAST)
      else $error("reserved vector used");
   // RL2: data abort wins
   dabt_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL2
      exc_req_i.data_abort && !halted_o |=> exc_enter_o && vec_addr_o == CEP_VEC_DABT)
      else $error("data abort not first");
   // RL5: fast before normal
   fast_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL5
      fast_rdy && irq_rdy && !exc_req_i.data_abort && !halted_o |=> vec_addr_o == CEP_VEC_FAST)
      else $error("normal beat fast");
   // RL7: entry in wide state
   wide_entry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL7
      exc_enter_o |-> wide_state_o)
      else $error("vector not in 32-bit state");
   // RL8: halt follows match
   halt_match_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL8
      dbg_match |=> halted_o)
      else $error("no halt on match");
   // RL12: link holds address of the instruction current at entry
   link_cap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL12
      take |=> lr_bank[mode_o] == $past(cur_pc_i))
      else $error("link not captured");
   // RL18: five-cycle fastest entry
   sequence fast_rise_s;
      $rose(|fast_src_i) ##1 (|fast_src_i)[*4];
   endsequence
   min_lat_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL18
      fast_rise_s and (!halted_o && !exc_enter_o && !exc_req_i.data_abort)[*5]
      |=> exc_enter_o && vec_addr_o == CEP_VEC_FAST)
      else $error("entry latency wrong");
   // RL20: reset enters vector zero
   rst_vec_a: assert property (@(posedge clk_sys_i) // RL20
      !rst_n_i |=> exc_enter_o && vec_addr_o == CEP_VEC_RESET && wide_state_o)
      else $error("reset not at vector zero");

endmodule

// ==== sim/cep_mem_model.sv ====
`timescale 1ns/1ns
// memory side of the shared bus, answers debug reads
module cep_mem_model
   import cep_pkg::*;
#(
   parameter logic [31:0] KEY = 32'h5a5a_0f0f
) (
   input  wire logic         clk_sys_i, // core clock
   input  wire cep_bus_req_t bus_i,     // request from the core
   output logic [31:0]       rdata_o    // read data
);
   initial rdata_o = 32'h0;
   // data is held for exactly one cycle after a request;
   // otherwise the lines toggle so stale data never looks valid
   always @(posedge clk_sys_i) begin
      #1;
      if (bus_i.valid === 1'b1 && bus_i.write === 1'b0) begin
         rdata_o = bus_i.addr ^ KEY;
      end else begin
         rdata_o = ~rdata_o;
      end
   end
endmodule

// ==== sim/cep_core_tb.sv ====
`timescale 1ns/1ns
module cep_core_tb
   import cep_pkg::*;
;
   localparam logic [31:0] KEY = 32'h5a5a_0f0f;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] irq_src_i, fast_src_i;
   logic [23:0] src_lvl_i;
   cep_exc_req_t exc_req_i;
   logic branch_link_i, compressed_i, wr_en_i, mac_start_i, mac_acc_i;
   logic [31:0] ret_addr_i, cur_pc_i, bus_addr_i, wr_data_i, mac_a_i, mac_b_i, bus_rdata_i;
   logic [3:0] wr_idx_i;
   cep_dbg_req_t dbg_i;
   cep_bus_req_t bus_o;
   logic [31:0] vec_addr_o, dbg_rdata_o;
   logic exc_enter_o, wide_state_o, halted_o, dbg_rvalid_o;
   cep_mode_t mode_o;
   logic [5:0] fetch_bits_o;
   logic [63:0] mac_result_o;
   int n_errors = 0;
   int tests_run = 0;

   cep_core dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .irq_src_i(irq_src_i),
      .fast_src_i(fast_src_i), .src_lvl_i(src_lvl_i), .exc_req_i(exc_req_i),
      .branch_link_i(branch_link_i), .ret_addr_i(ret_addr_i), .cur_pc_i(cur_pc_i),
      .bus_addr_i(bus_addr_i), .compressed_i(compressed_i), .wr_idx_i(wr_idx_i),
      .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .mac_start_i(mac_start_i),
      .mac_acc_i(mac_acc_i), .mac_a_i(mac_a_i), .mac_b_i(mac_b_i), .dbg_i(dbg_i),
      .bus_rdata_i(bus_rdata_i), .bus_o(bus_o), .vec_addr_o(vec_addr_o),
      .exc_enter_o(exc_enter_o), .mode_o(mode_o), .wide_state_o(wide_state_o),
      .fetch_bits_o(fetch_bits_o), .halted_o(halted_o), .dbg_rdata_o(dbg_rdata_o),
      .dbg_rvalid_o(dbg_rvalid_o), .mac_result_o(mac_result_o));

   cep_mem_model #(.KEY(KEY)) mem (.clk_sys_i(clk_sys_i), .bus_i(bus_o), .rdata_o(bus_rdata_i));

   always #2 clk_sys_i = ~clk_sys_i;

   task automatic report_and_stop();
      $display("checks run %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // inputs move 1 ns after the edge, away from sampling
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // watchers: reserved slot never entered, width follows state
   always @(posedge clk_sys_i) begin
      #1;
      if (rst_n_i === 1'b1 && exc_enter_o === 1'b1) begin
         check("reserved_slot", vec_addr_o === CEP_VEC_RSVD, 0);
         check("entry_in_table", vec_addr_o > 32'h1c, 0);
      end
      if (rst_n_i === 1'b1) begin
         check("fetch_bits", fetch_bits_o, wide_state_o === 1'b1 ? 32 : 16);
      end
   end

   task automatic t_reset();
      rst_n_i = 1'b0;
      tick(8);
      check("rst_enter", exc_enter_o, 1);
      check("rst_vec", vec_addr_o, CEP_VEC_RESET);
      check("rst_mode", mode_o, CEP_MODE_SVC);
      check("rst_wide", wide_state_o, 1);
      check("rst_halt", halted_o, 0);
      rst_n_i = 1'b1;
      tick(1);
   endtask

   task automatic sync_exc(input logic [3:0] r, input logic [31:0] pc, input logic [31:0] v,
                           input cep_mode_t m);
      exc_req_i = cep_exc_req_t'(r);
      cur_pc_i = pc;
      tick(1);
      check("enter", exc_enter_o, 1);
      check("vector", vec_addr_o, v);
      check("mode", mode_o, m);
      check("wide_entry", wide_state_o, 1);
      check("fetch_vec", {bus_o.valid, bus_o.fetch, bus_o.addr}, {2'b11, v});
      check("fetch_size", bus_o.size, CEP_SIZE_WORD);
      exc_req_i = '0;
      tick(1);
      check("enter_pulse", exc_enter_o, 0);
   endtask

   // both interrupt kinds need five edges from request to entry
   task automatic irq_enter(input logic f, input logic n, input logic [31:0] v,
                            input cep_mode_t m);
      fast_src_i = {2'b0, f, 5'b0};
      irq_src_i = {4'b0, n, 3'b0};
      for (int i = 1; i < 5; i++) begin
         tick(1);
         check("early_entry", exc_enter_o, 0);
      end
      tick(1);
      check("irq_enter", exc_enter_o, 1);
      check("irq_vector", vec_addr_o, v);
      check("irq_mode", mode_o, m);
      check("irq_wide", wide_state_o, 1);
      fast_src_i = '0;
      irq_src_i = '0;
      tick(1);
   endtask

   task automatic wr_reg(input logic [3:0] idx, input logic [31:0] d);
      wr_idx_i = idx;
      wr_data_i = d;
      wr_en_i = 1'b1;
      tick(1);
      wr_en_i = 1'b0;
      tick(1);
   endtask

   task automatic dbg_read(input logic [3:0] idx, input logic [31:0] exp);
      dbg_i.reg_idx = idx;
      dbg_i.reg_rd = 1'b1;
      tick(1);
      check("dbg_rvalid", dbg_rvalid_o, 1);
      check("dbg_reg", dbg_rdata_o, exp);
      dbg_i.reg_rd = 1'b0;
      tick(1);
   endtask

   // halt on a breakpoint, or on a watchpoint when wpt is set
   task automatic halt_on(input logic wpt, input logic [31:0] a);
      dbg_i.bkpt_val = a;
      dbg_i.wpt_val = a;
      dbg_i.bkpt_wr = ~wpt;
      dbg_i.wpt_wr = wpt;
      tick(1);
      dbg_i.bkpt_wr = 1'b0;
      dbg_i.wpt_wr = 1'b0;
      if (wpt) bus_addr_i = a;
      else cur_pc_i = a;
      for (int i = 0; i < 4 && halted_o !== 1'b1; i++) tick(1);
      check("halted", halted_o, 1);
      exc_req_i = 4'h8;
      tick(1);
      check("no_entry_halted", exc_enter_o, 0);
      exc_req_i = '0;
   endtask

   task automatic resume();
      cur_pc_i = 32'h0000_9000;
      bus_addr_i = 32'h0000_7000;
      tick(1);
      dbg_i.resume = 1'b1;
      tick(1);
      dbg_i.resume = 1'b0;
      check("resumed", halted_o, 0);
   endtask

   task automatic t_vectors();
      logic [3:0] code [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'he, 4'h6};
      logic [31:0] vec [6] = '{CEP_VEC_DABT, CEP_VEC_PABT, CEP_VEC_TRAP, CEP_VEC_UNDEF,
                               CEP_VEC_DABT, CEP_VEC_PABT};
      cep_mode_t md [6] = '{CEP_MODE_ABT, CEP_MODE_ABT, CEP_MODE_SVC, CEP_MODE_UND,
                            CEP_MODE_ABT, CEP_MODE_ABT};
      compressed_i = 1'b1;
      for (int i = 0; i < 6; i++) sync_exc(code[i], 32'h40 + i, vec[i], md[i]);
      irq_enter(1'b0, 1'b1, CEP_VEC_IRQ, CEP_MODE_IRQ);
      irq_enter(1'b1, 1'b1, CEP_VEC_FAST, CEP_MODE_FAST);
   endtask

   // banked stacks, link capture, fast bank and debug memory read
   task automatic t_banks();
      sync_exc(4'h8, 32'h100, CEP_VEC_DABT, CEP_MODE_ABT);
      wr_reg(4'd13, 32'ha0);
      wr_reg(4'd8, 32'h11);
      sync_exc(4'h1, 32'h200, CEP_VEC_UNDEF, CEP_MODE_UND);
      wr_reg(4'd13, 32'hb0);
      halt_on(1'b0, 32'h0000_2468);
      dbg_read(4'd13, 32'hb0);
      dbg_read(4'd14, 32'h200);
      dbg_i.mem_addr = 32'h0004_0010;
      dbg_i.mem_rd = 1'b1;
      tick(1);
      check("mem_req", {bus_o.valid, bus_o.write, bus_o.addr}, {2'b10, 32'h0004_0010});
      dbg_i.mem_rd = 1'b0;
      tick(1);
      check("mem_data", {dbg_rvalid_o, dbg_rdata_o}, {1'b1, 32'h0004_0010 ^ KEY});
      resume();
      irq_enter(1'b1, 1'b0, CEP_VEC_FAST, CEP_MODE_FAST);
      wr_reg(4'd8, 32'h88);
      sync_exc(4'h8, 32'h300, CEP_VEC_DABT, CEP_MODE_ABT);
      ret_addr_i = 32'h444;
      branch_link_i = 1'b1;
      tick(1);
      branch_link_i = 1'b0;
      halt_on(1'b1, 32'h0000_1234);
      dbg_read(4'd13, 32'ha0);
      dbg_read(4'd14, 32'h444);
      dbg_read(4'd8, 32'h11);
      resume();
   endtask

   task automatic t_mac();
      mac_a_i = 32'hffff_ffff;
      mac_b_i = 32'h2;
      mac_start_i = 1'b1;
      tick(1);
      check("mul", mac_result_o, 64'h1_ffff_fffe);
      mac_a_i = 32'h3;
      mac_b_i = 32'h5;
      mac_acc_i = 1'b1;
      tick(1);
      check("mac", mac_result_o, 64'h2_0000_000d);
      mac_start_i = 1'b0;
      mac_acc_i = 1'b0;
   endtask

   initial begin
      #(4 * 3000);
      n_errors++;
      report_and_stop();
   end

   initial begin
      irq_src_i = '0;
      fast_src_i = '0;
      src_lvl_i = 24'h05_3977;
      exc_req_i = '0;
      branch_link_i = 1'b0;
      compressed_i = 1'b0;
      wr_en_i = 1'b0;
      mac_start_i = 1'b0;
      mac_acc_i = 1'b0;
      ret_addr_i = 32'h0;
      cur_pc_i = 32'h0000_9000;
      bus_addr_i = 32'h0000_7000;
      wr_data_i = 32'h0;
      wr_idx_i = 4'h0;
      mac_a_i = 32'h0;
      mac_b_i = 32'h0;
      dbg_i = '0;
      t_reset();
      t_vectors();
      t_banks();
      t_mac();
      t_reset();
      report_and_stop();
   end
endmodule
